// file: design/ocr_pkg.sv
// constants for the offset trim and sysref clock register bank
package ocr_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam logic [11:0] OFS_HIGH_ADDR = 12'h025;
    localparam logic [11:0] OFS_LOW_ADDR  = 12'h026;
    localparam logic [11:0] CLK_CTRL_ADDR = 12'h030;
    localparam logic [11:0] CLK_STAT_ADDR = 12'h031;
    localparam logic [11:0] CLK_DLY_ADDR  = 12'h032;
    localparam logic [11:0] ANALOG_MISC_CONTROL_ADDR = 12'h033;
    localparam logic [11:0] CLAMP_ADDR    = 12'h034;
    localparam logic [11:0] RSVD_A_ADDR   = 12'h035;
    localparam logic [11:0] RSVD_B_ADDR   = 12'h036;
    localparam logic [11:0] RSVD_C_ADDR   = 12'h037;
    localparam logic [7:0] OFS_HIGH_RST = 8'h40;
    localparam logic [7:0] OFS_LOW_RST  = 8'h00;
    localparam logic [7:0] CLK_CTRL_RST = 8'hc0;
    localparam logic [7:0] CLK_STAT_RST = 8'h07;
    localparam logic [7:0] CLK_DLY_RST  = 8'h80;
    localparam logic [7:0] ANALOG_MISC_CONTROL_RST = 8'hc3;
    localparam logic [7:0] CLAMP_RST    = 8'h2f;
    localparam logic [7:0] RSVD_A_RST   = 8'hdf;
    localparam logic [7:0] RSVD_B_RST   = 8'h00;
    localparam logic [7:0] RSVD_C_RST   = 8'h45;
    localparam logic [14:0] OFS_MIDSCALE = 15'h4000;
    localparam int CTL_RX_EN   = 7;
    localparam int CTL_PROC_EN = 6;
    localparam int CTL_DET_CLR = 5;
    localparam int CTL_DIR_CLR = 4;
    localparam int CTL_CLK_DC  = 2;
    localparam int CTL_SYS_DC  = 1;
    localparam int CTL_SYN_DC  = 0;
    localparam int STAT_DET    = 7;
    localparam int STAT_DIRTY  = 6;
    localparam logic [5:0] STAT_LOW_FIXED = 6'h07;
endpackage

// file: design/ocr_regs.sv
// offset trim and sysref clock configuration register bank
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// R1 - the offset high register keeps trim bits 14..8 in bits 6..0 with bit 7 reserved.
// R2 - the offset low register keeps trim bits 7..0 and both join into one trim word.
// R3 - trim zero is most negative, 0x4000 is no offset and the reset value, all ones is most positive.
// R4 - one trim word drives the whole converter, every interleaved bank alike.
// R5 - while background calibration runs the trim word is ignored.
// R6 - the clock group sits at 0x030..0x037 with resets c0,07,80,c3,2f,df,00,45; 0x038..0x03f are reserved.
// R7 - control bit 7 enables the sysref receiver, reset 1.
// R8 - control bit 6 enables the sysref processor, reset 1.
// R9 - software drops the processor enable before the receiver enable and raises them the other way.
// R10 - writing 1 then 0 to control bit 5 clears the sysref detected flag; the bit resets to 0.
// R11 - writing 1 then 0 to control bit 4 clears the dirty capture flag; the bit resets to 0.
// R12 - control bits 2,1,0 pick dc lvpecl termination for clock, sysref and sync inputs; bit 3 reserved.
// R13 - a sysref rising edge sets status bit 7, the sysref detected flag, while control bits 7 and 6 are both 1.
// R14 - a sysref rising edge too near a clock edge sets status bit 6, the dirty capture flag, while control bits 7 and 6 are both 1.
// R15 - while a clear bit is 1 its flag stays 0 and detection resumes once the bit returns to 0.
// R16 - a reset restores every listed reset value; reserved bits in 0x025..0x037 except status 0x031 read back what was written, 0x038..0x03f read 0.
module ocr_regs (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [11:0] regAddr,
    input  wire logic [7:0]  regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [7:0]  regRdata,
    input  wire logic        sysrefEdge,
    input  wire logic        sysrefMarginal,
    input  wire logic        backgroundCalActive,
    output logic      [14:0] offsetTrimWord,
    output logic             sysrefReceiverEnable,
    output logic             sysrefProcessorEnable,
    output logic             clockInputDcTermination,
    output logic             sysrefInputDcTermination,
    output logic             syncInputDcTermination,
    output logic      [7:0]  sysrefDelayControl,
    output logic      [7:0]  analogMiscControl,
    output logic      [7:0]  inputClampControl
);
    typedef struct packed {
        logic [7:0]  ofsHigh;
        logic [7:0]  ofsLow;
        logic [7:0]  ctrl;
        logic [7:0]  dly;
        logic [7:0]  misc;
        logic [7:0]  clamp;
        logic [7:0]  rsvdA;
        logic [7:0]  rsvdB;
        logic [7:0]  rsvdC;
        logic        detFlag;
        logic        dirtyFlag;
        logic [14:0] trimOut;
        logic [7:0]  rdata;
    } ocr_state_t;

    ocr_state_t s_q;
    ocr_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.rdata = 8'h00;
        if (regWrite) begin
            case (regAddr)
                // R1 high byte store
                ocr_pkg::OFS_HIGH_ADDR: s_d.ofsHigh = regWdata;
                // R2 low byte store
                ocr_pkg::OFS_LOW_ADDR: s_d.ofsLow = regWdata;
                // R12 control byte store
                ocr_pkg::CLK_CTRL_ADDR: s_d.ctrl = regWdata;
                ocr_pkg::CLK_DLY_ADDR: s_d.dly = regWdata;
                ocr_pkg::ANALOG_MISC_CONTROL_ADDR: s_d.misc = regWdata;
                ocr_pkg::CLAMP_ADDR: s_d.clamp = regWdata;
                // R16 reserved bytes keep writes
                ocr_pkg::RSVD_A_ADDR: s_d.rsvdA = regWdata;
                ocr_pkg::RSVD_B_ADDR: s_d.rsvdB = regWdata;
                ocr_pkg::RSVD_C_ADDR: s_d.rsvdC = regWdata;
                default: s_d.rsvdC = s_q.rsvdC;
            endcase
        end
        // R13 detect sets flag
        if (sysrefEdge && s_q.ctrl[ocr_pkg::CTL_RX_EN] && s_q.ctrl[ocr_pkg::CTL_PROC_EN]) begin
            s_d.detFlag = 1'b1;
        end
        // R14 marginal capture sets flag
        if (sysrefEdge && sysrefMarginal && s_q.ctrl[ocr_pkg::CTL_RX_EN] && s_q.ctrl[ocr_pkg::CTL_PROC_EN]) begin
            s_d.dirtyFlag = 1'b1;
        end
        // R10 R15 clear held while bit set; the clear is a level, so it must win here
        if (s_q.ctrl[ocr_pkg::CTL_DET_CLR]) begin
            s_d.detFlag = 1'b0;
        end
        // R11 R15 dirty clear held
        if (s_q.ctrl[ocr_pkg::CTL_DIR_CLR]) begin
            s_d.dirtyFlag = 1'b0;
        end
        // R5 R4 freeze trim during calibration, one word for all banks
        if (!backgroundCalActive) begin
            s_d.trimOut = {s_q.ofsHigh[6:0], s_q.ofsLow};
        end
        if (regRead) begin
            // R6 clock group read map, unmapped reads zero
            case (regAddr)
                ocr_pkg::OFS_HIGH_ADDR: s_d.rdata = s_q.ofsHigh;
                ocr_pkg::OFS_LOW_ADDR: s_d.rdata = s_q.ofsLow;
                ocr_pkg::CLK_CTRL_ADDR: s_d.rdata = s_q.ctrl;
                ocr_pkg::CLK_STAT_ADDR: s_d.rdata = {s_q.detFlag, s_q.dirtyFlag, ocr_pkg::STAT_LOW_FIXED};
                ocr_pkg::CLK_DLY_ADDR: s_d.rdata = s_q.dly;
                ocr_pkg::ANALOG_MISC_CONTROL_ADDR: s_d.rdata = s_q.misc;
                ocr_pkg::CLAMP_ADDR: s_d.rdata = s_q.clamp;
                ocr_pkg::RSVD_A_ADDR: s_d.rdata = s_q.rsvdA;
                ocr_pkg::RSVD_B_ADDR: s_d.rdata = s_q.rsvdB;
                ocr_pkg::RSVD_C_ADDR: s_d.rdata = s_q.rsvdC;
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // R16 R3 reset values, midscale trim
            s_q.ofsHigh   <= ocr_pkg::OFS_HIGH_RST;
            s_q.ofsLow    <= ocr_pkg::OFS_LOW_RST;
            s_q.ctrl      <= ocr_pkg::CLK_CTRL_RST;
            s_q.dly       <= ocr_pkg::CLK_DLY_RST;
            s_q.misc      <= ocr_pkg::ANALOG_MISC_CONTROL_RST;
            s_q.clamp     <= ocr_pkg::CLAMP_RST;
            s_q.rsvdA     <= ocr_pkg::RSVD_A_RST;
            s_q.rsvdB     <= ocr_pkg::RSVD_B_RST;
            s_q.rsvdC     <= ocr_pkg::RSVD_C_RST;
            s_q.detFlag   <= 1'b0;
            s_q.dirtyFlag <= 1'b0;
            s_q.trimOut   <= ocr_pkg::OFS_MIDSCALE;
            s_q.rdata     <= 8'h00;
        end else begin
            s_q <= s_d;
        end
    end

    assign regRdata                 = s_q.rdata;
    assign offsetTrimWord           = s_q.trimOut;
    // R7 receiver enable
    assign sysrefReceiverEnable     = s_q.ctrl[ocr_pkg::CTL_RX_EN];
    // R8 R9 processor needs receiver; ordering is software's job
    assign sysrefProcessorEnable    = s_q.ctrl[ocr_pkg::CTL_PROC_EN];
    // R12 termination selects
    assign clockInputDcTermination  = s_q.ctrl[ocr_pkg::CTL_CLK_DC];
    assign sysrefInputDcTermination = s_q.ctrl[ocr_pkg::CTL_SYS_DC];
    assign syncInputDcTermination   = s_q.ctrl[ocr_pkg::CTL_SYN_DC];
    assign sysrefDelayControl       = s_q.dly;
    assign analogMiscControl        = s_q.misc;
    assign inputClampControl        = s_q.clamp;
endmodule // ocr_regs

// file: test/ocr_regs_properties.sv
// assertions for the offset trim and sysref clock register bank
`timescale 1ns/1ps
module ocr_regs_properties (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [11:0] regAddr,
    input wire logic [7:0]  regWdata,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [7:0]  regRdata,
    input wire logic        backgroundCalActive,
    input wire logic [14:0] offsetTrimWord,
    input wire logic        sysrefReceiverEnable,
    input wire logic        sysrefProcessorEnable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_unmapped; regRead && regAddr[11:3] == 9'h007 |=> regRdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_stat_low; regRead && regAddr == 12'h031 |=> regRdata[5:0] == 6'h07; endproperty
    a_stat_low: assert property (p_stat_low) else $error("status low bits wrong");
    property p_trim_hi;
        regWrite && regAddr == 12'h025 && !backgroundCalActive ##1 !backgroundCalActive
            |=> offsetTrimWord[14:8] == $past(regWdata[6:0], 2);
    endproperty
    a_trim_hi: assert property (p_trim_hi) else $error("trim high bits wrong");
    property p_trim_lo;
        regWrite && regAddr == 12'h026 && !backgroundCalActive ##1 !backgroundCalActive
            |=> offsetTrimWord[7:0] == $past(regWdata, 2);
    endproperty
    a_trim_lo: assert property (p_trim_lo) else $error("trim low bits wrong");
    property p_frozen; backgroundCalActive[*3] |=> $stable(offsetTrimWord); endproperty
    a_frozen: assert property (p_frozen) else $error("trim moved during calibration");
    property p_enables;
        regWrite && regAddr == 12'h030 |=> {sysrefReceiverEnable, sysrefProcessorEnable} == $past(regWdata[7:6]);
    endproperty
    a_enables: assert property (p_enables) else $error("sysref enables wrong");
    property p_det_clr;
        regWrite && regAddr == 12'h030 && regWdata[5] ##2 regRead && regAddr == 12'h031 |=> !regRdata[7];
    endproperty
    a_det_clr: assert property (p_det_clr) else $error("detect flag not held clear");
    property p_dirty_clr;
        regWrite && regAddr == 12'h030 && regWdata[4] ##2 regRead && regAddr == 12'h031 |=> !regRdata[6];
    endproperty
    a_dirty_clr: assert property (p_dirty_clr) else $error("dirty flag not held clear");
    c_stat_read: cover property (regRead && regAddr == 12'h031);
    c_cal_write: cover property (backgroundCalActive && regWrite);
    c_unmapped: cover property (regRead && regAddr == 12'h038);
endmodule // ocr_regs_properties
bind ocr_regs ocr_regs_properties chk (.*);

// file: test/tb_top.sv
// self-checking bench for the offset trim and sysref clock register bank
`timescale 1ns/1ps
module tb_top;
    logic clk, rst_n, regWrite, regRead, sysrefEdge, sysrefMarginal, backgroundCalActive;
    logic [11:0] regAddr;
    logic [7:0]  regWdata, regRdata, sysrefDelayControl, analogMiscControl, inputClampControl;
    logic [14:0] offsetTrimWord;
    logic        sysrefReceiverEnable, sysrefProcessorEnable;
    logic        clockInputDcTermination, sysrefInputDcTermination, syncInputDcTermination;
    int          errors, samples_checked;
    ocr_regs dut (.*);
    task automatic chk(input logic [14:0] seen, input logic [14:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        {regWrite, regAddr, regWdata} <= {1'b1, a, d};
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk);
        {regRead, regAddr} <= {1'b1, a};
        @(posedge clk);
        regRead <= 1'b0;
        #1 chk(15'(regRdata), 15'(e));
    endtask
    task automatic pulse(input logic m);
        @(posedge clk);
        {sysrefEdge, sysrefMarginal} <= {1'b1, m};
        @(posedge clk);
        sysrefEdge <= 1'b0;
    endtask
    task automatic t_reset;
        logic [7:0] rv [10] = '{8'h40, 8'h00, 8'hc0, 8'h07, 8'h80, 8'hc3, 8'h2f, 8'hdf, 8'h00, 8'h45};
        chk(offsetTrimWord, 15'h4000);
        chk(15'({sysrefReceiverEnable, sysrefProcessorEnable}), 15'h3);
        chk(15'({clockInputDcTermination, sysrefInputDcTermination, syncInputDcTermination}), 15'h0);
        chk(15'(sysrefDelayControl), 15'h80);
        chk(15'(analogMiscControl), 15'hc3);
        chk(15'(inputClampControl), 15'h2f);
        for (int i = 0; i < 10; i++)
            rd(i < 2 ? 12'h025 + 12'(i) : 12'h02e + 12'(i), rv[i]);
    endtask
    task automatic t_regs;
        wr(12'h025, 8'hff);
        rd(12'h025, 8'hff);
        wr(12'h037, 8'h5a);
        rd(12'h037, 8'h5a);
        wr(12'h032, 8'h3c);
        wr(12'h033, 8'ha5);
        wr(12'h034, 8'h96);
        #1 chk(15'({sysrefDelayControl, analogMiscControl[7:1]}), 15'({8'h3c, 7'h52}));
        chk(15'({analogMiscControl[0], inputClampControl}), 15'({1'b1, 8'h96}));
        wr(12'h038, 8'h5a);
        rd(12'h038, 8'h00);
        wr(12'h031, 8'hff);
        rd(12'h031, 8'h07);
        wr(12'h026, 8'hff);
        @(posedge clk) #1 chk(offsetTrimWord, 15'h7fff);
        backgroundCalActive <= 1'b1;
        wr(12'h025, 8'h00);
        wr(12'h026, 8'h00);
        repeat (2) @(posedge clk);
        #1 chk(offsetTrimWord, 15'h7fff);
        backgroundCalActive <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk(offsetTrimWord, 15'h0000);
    endtask
    task automatic t_sysref;
        wr(12'h030, 8'hc5);
        #1 chk(15'({clockInputDcTermination, sysrefInputDcTermination, syncInputDcTermination}), 15'h5);
        pulse(1'b1);
        rd(12'h031, 8'hc7);
        wr(12'h030, 8'hf0);
        rd(12'h031, 8'h07);
        pulse(1'b1);
        rd(12'h031, 8'h07);
        wr(12'h030, 8'hc0);
        pulse(1'b0);
        rd(12'h031, 8'h87);
        // processor off before receiver, also clears the flag
        wr(12'h030, 8'ha0);
        wr(12'h030, 8'h00);
        pulse(1'b0);
        rd(12'h031, 8'h07);
        chk(15'({sysrefReceiverEnable, sysrefProcessorEnable}), 15'h0);
        wr(12'h030, 8'h80);
        wr(12'h030, 8'hc0);
    endtask
    task automatic stop_test;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        {rst_n, regWrite, regRead, sysrefEdge, sysrefMarginal, backgroundCalActive} = '0;
        {regAddr, regWdata} = '0;
        {errors, samples_checked} = '0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_sysref();
        stop_test();
    end
    // watchdog so a hung run still reaches the verdict
    initial begin
        #100000;
        errors++;
        stop_test();
    end
endmodule // tb_top
